//--- src/hbdc_pkg.sv
package hbdc_pkg;

  // Clock rate in kHz, used to turn printed times into cycle counts.
  localparam int unsigned CLK_KHZ = 100000;

  // Printed times in their own units.
  localparam int unsigned STANDBY_ENTRY_DELAY_US = 1000;
  localparam int unsigned WAKE_QUALIFY_US        = 5;
  localparam int unsigned WAKE_TIME_US           = 60;
  localparam int unsigned DEAD_TIME_NS           = 200;
  localparam int unsigned REGULATION_OFF_TIME_US = 25;
  localparam int unsigned OC_RETRY_US            = 3000;

  // Cycle counts derived from the rate; least times round up.
  localparam int unsigned STANDBY_CYC = (STANDBY_ENTRY_DELAY_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned QUALIFY_CYC = (WAKE_QUALIFY_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned WAKE_CYC    = (WAKE_TIME_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned DEAD_CYC    = (DEAD_TIME_NS * CLK_KHZ / 1000 + 999) / 1000;
  localparam int unsigned OFF_CYC     = (REGULATION_OFF_TIME_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned RETRY_CYC   = (OC_RETRY_US * CLK_KHZ + 999) / 1000;

  // Counter width covers the longest count.
  localparam int unsigned CNT_W = 20;

  // Bridge drive states after decode and override.
  typedef enum logic [1:0] {
    HBDC_COAST,
    HBDC_REVERSE,
    HBDC_FORWARD,
    HBDC_BRAKE
  } hbdc_drive_t;

  // Power and wake sequencing states.
  typedef enum logic [1:0] {
    HBDC_PWR_STANDBY,
    HBDC_PWR_QUALIFY,
    HBDC_PWR_WAKE,
    HBDC_PWR_RUN
  } hbdc_pwr_t;

endpackage : hbdc_pkg

//--- src/hbdc_drive_control.sv
`timescale 1ns/1ps
// How it works
// - Both inputs low: all switches off, coast.
// - A low, B high: drive reverse.
// - A high, B low: drive forward.
// - Both high: brake through both low sides.
// - Inputs low past entry delay: enter standby.
// - Standby holds both outputs high impedance.
// - Input high 5us, operational 60us later.
// - Dead interval between switches of a half-bridge.
// - High and low side never on together.
// - Current trip: low sides on for off-time.
// - Mixed decay: inverted first half, slow second.
// - Over-temperature disables all until it clears.
// - Overcurrent on any switch disables everything.
// - Overcurrent retry after 3ms if cleared.
// - Undervoltage disables switches until supply recovers.
module hbdc_drive_control #(
  parameter int unsigned STANDBY_CYC_P = hbdc_pkg::STANDBY_CYC,
  parameter int unsigned RETRY_CYC_P   = hbdc_pkg::RETRY_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic direction_input_a_i,
  input  wire logic direction_input_b_i,
  input  wire logic current_trip_i,
  input  wire logic overcurrent_i,
  input  wire logic thermal_shutdown_i,
  input  wire logic supply_undervoltage_i,
  input  wire logic mixed_decay_i,
  output logic      high_side_a_o,
  output logic      low_side_a_o,
  output logic      high_side_b_o,
  output logic      low_side_b_o,
  output logic      supplies_on_o,
  output logic      standby_o
);

  localparam int unsigned W = hbdc_pkg::CNT_W;

  // Two-stage synchronisers; stage one is read only by stage two.
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
    end else begin
      sync1_reg <= {mixed_decay_i, supply_undervoltage_i, thermal_shutdown_i,
                    overcurrent_i, current_trip_i, direction_input_b_i,
                    direction_input_a_i};
      sync2_reg <= sync1_reg;
    end
  end

  logic in_a, in_b, trip, oc_flag, hot_flag, uv_flag, mixed;
  assign in_a  = sync2_reg[0];
  assign in_b  = sync2_reg[1];
  assign trip  = sync2_reg[2];
  assign oc_flag  = sync2_reg[3];
  assign hot_flag = sync2_reg[4];
  assign uv_flag  = sync2_reg[5];
  assign mixed = sync2_reg[6];

  // Standby and wake sequencing. The device starts asleep, so a host must wake it.
  hbdc_pkg::hbdc_pwr_t pwr_reg;
  logic [W-1:0]        pwr_cnt_reg;
  logic                any_in;
  assign any_in = in_a | in_b;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pwr_reg     <= hbdc_pkg::HBDC_PWR_STANDBY;
      pwr_cnt_reg <= '0;
    end else begin
      unique case (pwr_reg)
        hbdc_pkg::HBDC_PWR_STANDBY: begin
          pwr_cnt_reg <= '0;
          if (any_in) pwr_reg <= hbdc_pkg::HBDC_PWR_QUALIFY;
        end
        hbdc_pkg::HBDC_PWR_QUALIFY: begin
          // A short glitch drops back without waking.
          if (!any_in) begin
            pwr_reg     <= hbdc_pkg::HBDC_PWR_STANDBY;
            pwr_cnt_reg <= '0;
          end else if (pwr_cnt_reg == W'(hbdc_pkg::QUALIFY_CYC - 1)) begin
            pwr_reg     <= hbdc_pkg::HBDC_PWR_WAKE;
            pwr_cnt_reg <= '0;
          end else begin
            pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
          end
        end
        hbdc_pkg::HBDC_PWR_WAKE: begin
          if (pwr_cnt_reg == W'(hbdc_pkg::WAKE_CYC - 1)) begin
            pwr_reg     <= hbdc_pkg::HBDC_PWR_RUN;
            pwr_cnt_reg <= '0;
          end else begin
            pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
          end
        end
        hbdc_pkg::HBDC_PWR_RUN: begin
          if (any_in) begin
            pwr_cnt_reg <= '0;
          end else if (pwr_cnt_reg == W'(STANDBY_CYC_P)) begin
            pwr_reg     <= hbdc_pkg::HBDC_PWR_STANDBY;
            pwr_cnt_reg <= '0;
          end else begin
            pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // Overcurrent latch with retry timer; retries only once the flag is gone.
  logic         oc_reg;
  logic [W-1:0] oc_cnt_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      oc_reg     <= 1'b0;
      oc_cnt_reg <= '0;
    end else if (oc_flag) begin
      oc_reg     <= 1'b1;
      oc_cnt_reg <= '0;
    end else if (oc_reg) begin
      if (oc_cnt_reg >= W'(RETRY_CYC_P - 1)) begin
        oc_reg     <= 1'b0;
        oc_cnt_reg <= '0;
      end else begin
        oc_cnt_reg <= oc_cnt_reg + 1'b1;
      end
    end
  end

  logic fault;
  assign fault = oc_reg | hot_flag | uv_flag;

  // Regulation off-time. A trip during the off-time does not restart it.
  logic         off_reg;
  logic [W-1:0] off_cnt_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || fault) begin
      off_reg     <= 1'b0;
      off_cnt_reg <= '0;
    end else if (!off_reg) begin
      off_reg     <= trip && pwr_reg == hbdc_pkg::HBDC_PWR_RUN;
      off_cnt_reg <= '0;
    end else if (off_cnt_reg == W'(hbdc_pkg::OFF_CYC - 1)) begin
      off_reg     <= 1'b0;
      off_cnt_reg <= '0;
    end else begin
      off_cnt_reg <= off_cnt_reg + 1'b1;
    end
  end

  // Decode and override into one target drive state.
  hbdc_pkg::hbdc_drive_t want;
  always_comb begin
    unique case ({in_a, in_b})
      2'b00:   want = hbdc_pkg::HBDC_COAST;
      2'b01:   want = hbdc_pkg::HBDC_REVERSE;
      2'b10:   want = hbdc_pkg::HBDC_FORWARD;
      default: want = hbdc_pkg::HBDC_BRAKE;
    endcase
    if (off_reg) begin
      if (mixed && off_cnt_reg < W'(hbdc_pkg::OFF_CYC / 2)) begin
        unique case ({in_a, in_b})
          2'b01:   want = hbdc_pkg::HBDC_FORWARD;
          2'b10:   want = hbdc_pkg::HBDC_REVERSE;
          default: want = hbdc_pkg::HBDC_BRAKE;
        endcase
      end else begin
        want = hbdc_pkg::HBDC_BRAKE;
      end
    end
    if (pwr_reg != hbdc_pkg::HBDC_PWR_RUN) want = hbdc_pkg::HBDC_COAST;
    if (fault) want = hbdc_pkg::HBDC_COAST;
  end

  // Per half-bridge request: 2'b10 high on, 2'b01 low on, 2'b00 both off.
  logic [1:0] req_a, req_b;
  always_comb begin
    unique case (want)
      hbdc_pkg::HBDC_COAST:   begin req_a = 2'b00; req_b = 2'b00; end
      hbdc_pkg::HBDC_REVERSE: begin req_a = 2'b01; req_b = 2'b10; end
      hbdc_pkg::HBDC_FORWARD: begin req_a = 2'b10; req_b = 2'b01; end
      hbdc_pkg::HBDC_BRAKE:   begin req_a = 2'b01; req_b = 2'b01; end
    endcase
  end

  // Handshake per half-bridge: a switch turns on only after both have been off
  // for the dead interval. Turning off is immediate, so faults act at once.
  logic [1:0] req [2];
  assign req[0] = req_a;
  assign req[1] = req_b;
  logic [1:0] sw_reg [2];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_half
      logic [7:0] dead_cnt_reg;
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          sw_reg[g]    <= 2'b00;
          dead_cnt_reg <= 8'h00;
        end else if (sw_reg[g] != 2'b00 && sw_reg[g] != req[g]) begin
          sw_reg[g]    <= 2'b00;
          dead_cnt_reg <= 8'h00;
        end else if (sw_reg[g] == 2'b00) begin
          if (dead_cnt_reg < 8'(hbdc_pkg::DEAD_CYC)) begin
            dead_cnt_reg <= dead_cnt_reg + 8'h01;
          end else begin
            sw_reg[g] <= req[g];
          end
        end
      end
    end
  endgenerate

  assign high_side_a_o = sw_reg[0][1];
  assign low_side_a_o  = sw_reg[0][0];
  assign high_side_b_o = sw_reg[1][1];
  assign low_side_b_o  = sw_reg[1][0];

  // Qualification still counts as standby, so a short glitch never powers up the supplies.
  logic asleep;
  assign asleep = (pwr_reg == hbdc_pkg::HBDC_PWR_STANDBY) ||
                  (pwr_reg == hbdc_pkg::HBDC_PWR_QUALIFY);

  // Supplies drop on thermal or overcurrent shutdown and while asleep.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      supplies_on_o <= 1'b0;
      standby_o     <= 1'b1;
    end else begin
      supplies_on_o <= !(hot_flag | oc_reg) && !asleep;
      standby_o     <= asleep;
    end
  end

endmodule : hbdc_drive_control

//--- verification/hbdc_drive_control_properties.sv
`timescale 1ns/1ps
module hbdc_drive_props #(
  parameter int unsigned STANDBY_CYC_P = 50
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic direction_input_a_i,
  input wire logic direction_input_b_i,
  input wire logic overcurrent_i,
  input wire logic thermal_shutdown_i,
  input wire logic supply_undervoltage_i,
  input wire logic high_side_a_o,
  input wire logic low_side_a_o,
  input wire logic high_side_b_o,
  input wire logic low_side_b_o,
  input wire logic supplies_on_o,
  input wire logic standby_o
);
  logic [7:0]  gap_reg;
  logic [19:0] low_reg;
  logic [9:0]  hi_reg;
  logic        qual_reg;
  // Off cycles of half A, saturating so a long idle never wraps.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || high_side_a_o || low_side_a_o) gap_reg <= 8'h00;
    else if (gap_reg != 8'hff) gap_reg <= gap_reg + 8'h01;
  end
  // Quiet inputs; a fault restarts it, since standby is not promised then.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || direction_input_a_i || direction_input_b_i || overcurrent_i ||
        thermal_shutdown_i || supply_undervoltage_i) low_reg <= '0;
    else if (low_reg != 20'hfffff) low_reg <= low_reg + 20'h00001;
  end
  // Wake qualification seen while still in standby.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !(direction_input_a_i || direction_input_b_i)) hi_reg <= '0;
    else if (hi_reg != 10'h3ff) hi_reg <= hi_reg + 10'h001;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !standby_o) qual_reg <= 1'b0;
    else if (hi_reg >= hbdc_pkg::QUALIFY_CYC) qual_reg <= 1'b1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_off;
    !high_side_a_o && !low_side_a_o && !high_side_b_o && !low_side_b_o;
  endsequence
  sequence s_hot;
    thermal_shutdown_i [*4];
  endsequence
  // Overcurrent passes the retry latch first, so it acts one cycle after the other flags.
  sequence s_oc;
    overcurrent_i [*5];
  endsequence
  a_no_shoot_a: assert property (!(high_side_a_o && low_side_a_o))
    else $error("half A both switches on");
  a_no_shoot_b: assert property (!(high_side_b_o && low_side_b_o))
    else $error("half B both switches on");
  a_dead_gap_a: assert property ($rose(high_side_a_o) |-> gap_reg >= hbdc_pkg::DEAD_CYC)
    else $error("dead interval too short");
  a_standby_hiz: assert property (standby_o |-> s_off)
    else $error("switch on in standby");
  a_hot_off: assert property (s_hot |-> s_off ##0 !supplies_on_o)
    else $error("bridge live while hot");
  a_oc_off: assert property (s_oc |-> s_off ##0 !supplies_on_o)
    else $error("bridge live in overcurrent");
  a_uv_off: assert property (supply_undervoltage_i [*4] |-> s_off)
    else $error("bridge live in undervoltage");
  a_sleep_entry: assert property (low_reg == STANDBY_CYC_P + 8 |-> standby_o)
    else $error("standby not entered");
  a_wake_qual: assert property ($fell(standby_o) |-> qual_reg)
    else $error("woke without qualification");
endmodule : hbdc_drive_props

//--- verification/hbdc_host_model.sv
`timescale 1ns/1ps
module hbdc_host_model #(
  parameter int unsigned HOLD_CYC = 500
) (
  input  wire logic       clk_i,
  input  wire logic [1:0] cmd_i,
  output logic            direction_input_a_o,
  output logic            direction_input_b_o
);
  logic [1:0]  lvl_reg  = 2'h0;
  int unsigned held_reg = HOLD_CYC;
  // Each level stands at least 500 cycles (5 us), so the inputs never toggle above 100 kHz.
  // A command that comes sooner waits here; levels are static between commands.
  always @(posedge clk_i) begin
    if (cmd_i != lvl_reg && held_reg >= HOLD_CYC) begin
      lvl_reg  <= cmd_i;
      held_reg <= 1;
    end else if (held_reg < HOLD_CYC) begin
      held_reg <= held_reg + 1;
    end
  end
  assign direction_input_a_o = lvl_reg[1];
  assign direction_input_b_o = lvl_reg[0];
endmodule : hbdc_host_model

//--- verification/hbdc_drive_control_tb.sv
`timescale 1ns/1ps
module hbdc_drive_control_tb;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic       dia, dib, hsa, lsa, hsb, lsb, sup, stby;
  logic       trip = 1'b0, oc = 1'b0, hot = 1'b0, uv = 1'b0, mix = 1'b0;
  int         fail_count = 0;
  int         checked = 0;
  // Shortened standby delay, still well above the host's 500-cycle level hold.
  localparam int unsigned STANDBY_P = 1000;
  always #5 clk_i = ~clk_i;
  hbdc_host_model host_u (.clk_i(clk_i), .cmd_i(cmd), .direction_input_a_o(dia),
    .direction_input_b_o(dib));
  hbdc_drive_control #(.STANDBY_CYC_P(STANDBY_P), .RETRY_CYC_P(100)) dut_u (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .direction_input_a_i(dia), .direction_input_b_i(dib),
    .current_trip_i(trip), .overcurrent_i(oc), .thermal_shutdown_i(hot),
    .supply_undervoltage_i(uv), .mixed_decay_i(mix), .high_side_a_o(hsa),
    .low_side_a_o(lsa), .high_side_b_o(hsb), .low_side_b_o(lsb),
    .supplies_on_o(sup), .standby_o(stby));
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // Steps past edges and looks after outputs settle; a missed bound ends the run.
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : step
  task automatic wait_sw(input logic [3:0] exp, input int lim, output int n);
    for (n = 0; {hsa, lsa, hsb, lsb} !== exp; n++) begin
      step(1);
      if (n > lim) begin
        check("switch wait", {hsa, lsa, hsb, lsb}, exp);
        give_verdict();
      end
    end
  endtask : wait_sw
  task automatic t_wake;
    int n;
    check("reset state", {2'h0, sup, stby}, 4'h1);
    @(posedge clk_i) cmd <= 2'h2;
    step(100);
    check("qualify in standby", {2'h0, sup, stby}, 4'h1);
    wait_sw(4'h9, 8000, n);
    check("wake late enough", 4'(n + 100 >= 6500), 4'h1);
  endtask : t_wake
  task automatic t_table;
    logic [1:0] c [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
    logic [3:0] e [4] = '{4'h6, 4'h5, 4'h0, 4'h9};
    int n;
    foreach (c[i]) begin
      @(posedge clk_i) cmd <= c[i];
      wait_sw(e[i], 600, n);
      check("decoded state", {hsa, lsa, hsb, lsb}, e[i]);
    end
  endtask : t_table
  // Trip pulse is short: a held trip would simply re-arm after the off time.
  task automatic t_trip(input logic m);
    int n;
    @(posedge clk_i) mix <= m;
    repeat (4) @(posedge clk_i);
    trip <= 1'b1;
    repeat (5) @(posedge clk_i);
    trip <= 1'b0;
    if (m) wait_sw(4'h6, 60, n);
    wait_sw(4'h5, 1400, n);
    step(2400);
    if (!m) check("off time brake", {hsa, lsa, hsb, lsb}, 4'h5);
    wait_sw(4'h9, 1500, n);
    check("drive resumed", {hsa, lsa, hsb, lsb}, 4'h9);
  endtask : t_trip
  task automatic t_fault(input logic [2:0] f);
    int n;
    @(posedge clk_i) {hot, oc, uv} <= f;
    step(10);
    check("fault switches", {hsa, lsa, hsb, lsb}, 4'h0);
    if (!f[0]) check("supplies off", {3'h0, sup}, 4'h0);
    @(posedge clk_i) {hot, oc, uv} <= 3'h0;
    step(60);
    if (f[1]) check("retry hold", {hsa, lsa, hsb, lsb}, 4'h0);
    wait_sw(4'h9, 300, n);
  endtask : t_fault
  task automatic t_sleep;
    @(posedge clk_i) cmd <= 2'h0;
    step(STANDBY_P);
    check("early standby", {3'h0, stby}, 4'h0);
    step(15);
    check("standby entered", {hsa, lsa, hsb, stby}, 4'h1);
  endtask : t_sleep
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    step(1);
    t_wake();
    t_table();
    t_trip(1'b0);
    t_trip(1'b1);
    t_fault(3'h4);
    t_fault(3'h2);
    t_fault(3'h1);
    t_sleep();
    give_verdict();
  end
endmodule : hbdc_drive_control_tb
bind hbdc_drive_control hbdc_drive_props #(.STANDBY_CYC_P(STANDBY_CYC_P)) chk_u (.clk_i,
  .rst_n_i, .direction_input_a_i, .direction_input_b_i, .overcurrent_i,
  .thermal_shutdown_i, .supply_undervoltage_i, .high_side_a_o, .low_side_a_o,
  .high_side_b_o, .low_side_b_o, .supplies_on_o, .standby_o);
